//--- design/blind_command_sequencer.sv
// Blind command sequencer: one input, shutter or venetian blind mode.
// Assumes an APB master and a bus transceiver that sends the pulses.
//
// What this block does
// RULE1: Emits move, stop-step and stop one-bit commands with direction bit.
// RULE2: Actuator starts travelling in the commanded direction on move.
// RULE3: Actuator steps when still, only halts when moving, on stop-step.
// RULE4: Actuator halts any travel on a dedicated stop.
// RULE5: Shutter mode drives at least move and dedicated stop.
// RULE6: Venetian mode drives at least move and stop-step.
// RULE7: Actuator always takes move and stop-step; stop is optional.
// RULE8: Shutter mode sends move at once when the input is pressed.
// RULE9: Toggle option reverses direction on every activation.
// RULE10: Shutter quick release sends nothing; a later long press stops.
// RULE11: Shutter long press release sends stop.
// RULE12: Venetian short press release sends stop-step.
// RULE13: Venetian hold reaching threshold sends move.
// RULE14: Venetian short press during travel sends stop-step.
// RULE15: Manual mode ignores physical input, uses keypad button only.
// RULE16: Keypad press in manual mode produces same commands as input.
// RULE17: Keypad LED lit while channel contact regarded closed.
// RULE18: Manual button enters manual mode, lights its LED.
// RULE19: Second manual button press returns to physical inputs.
// RULE20: Leaving manual mode resyncs input to physical level.
// RULE21: Without toggle, direction is the fixed configured one.
// RULE22: Blinds option picks step or stop for the short press.
// RULE23: Press is long after configurable threshold, short if earlier.
// RULE24: Inputs and buttons are debounced to one event per actuation.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "blind_seq_defs.svh"

module blind_command_sequencer (
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Contacts
   input  wire logic        phys_in,
   input  wire logic        key_in,
   input  wire logic        manual_key_in,
   // Indicators
   output logic             key_led_out,
   output logic             manual_led_out,
   // One-bit command objects towards the bus transceiver
   output logic             move_send_out,
   output logic             step_send_out,
   output logic             stop_send_out,
   output logic             cmd_dir_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      // Software-written configuration
      logic [2:0]                   ctrl;
      logic [15:0]                  long_ms;
      // Mode, edge detector and press tracking
      logic                         manual;
      logic                         resync;
      logic                         prev_in;
      logic                         prev_man;
      blind_seq_pkg::press_state_t  press;
      logic [15:0]                  held_ms;
      logic [`MS_CNT_W-1:0]         tick_cnt;
      logic                         dir;
      logic                         moving;
      logic                         move;
      logic                         step;
      logic                         stop;
      logic [3:0]                   last_cmd;
      logic [31:0]                  rdata;
   } seq_state_t;

   seq_state_t st_r;
   seq_state_t st_nxt;

   // Debounced levels and decoded events
   logic phys_lvl;
   logic key_lvl;
   logic man_lvl;
   logic in_lvl;
   logic rise;
   logic fall;
   logic ms_tick;
   logic long_hit;
   logic act_dir;
   // Bus phases
   logic apb_wr;
   logic apb_rd;

   // ---------------------------------------------------------------
   // Debounced contacts
   // ---------------------------------------------------------------
   // Physical contact is settled in both modes, so its level is
   // ready the moment manual mode ends
   input_debounce u_deb_phys (
      .ref_clk_in   (ref_clk_in),
      .resetn_in    (resetn_in),
      .raw_in       (phys_in),
      .force_in     (1'b0),
      .force_val_in (1'b0),
      .level_out    (phys_lvl)
   );

   // Keypad contact is flushed open when manual mode ends
   input_debounce u_deb_key (
      .ref_clk_in   (ref_clk_in),
      .resetn_in    (resetn_in),
      .raw_in       (key_in),
      .force_in     (!st_r.manual),
      .force_val_in (1'b0),
      .level_out    (key_lvl)
   );

   // The manual-mode button is live in both modes
   input_debounce u_deb_man (
      .ref_clk_in   (ref_clk_in),
      .resetn_in    (resetn_in),
      .raw_in       (manual_key_in),
      .force_in     (1'b0),
      .force_val_in (1'b0),
      .level_out    (man_lvl)
   );

   // ---------------------------------------------------------------
   // Register map decode
   // ---------------------------------------------------------------
   function automatic logic is_addr(input logic [11:0] a,
                                    input logic [11:0] ref_a);
      is_addr = (a == ref_a);
   endfunction : is_addr

   // One list of offsets, so the error flag and the map cannot drift
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = is_addr(a, `ADDR_CTRL)
                  || is_addr(a, `ADDR_LONG)
                  || is_addr(a, `ADDR_STATUS)
                  || is_addr(a, `ADDR_CMD);
   endfunction : is_mapped

   // ---------------------------------------------------------------
   // Event decode
   // ---------------------------------------------------------------
   always_comb begin
      in_lvl   = st_r.manual ? key_lvl : phys_lvl;             // [RULE15]
      rise     = in_lvl && !st_r.prev_in && !st_r.resync;
      fall     = !in_lvl && st_r.prev_in && !st_r.resync;
      ms_tick  = (st_r.tick_cnt == `MS_CNT_W'(`MS_CYCLES));
      long_hit = ms_tick && (st_r.press == blind_seq_pkg::PR_SHORT)
                 && (st_r.held_ms + 16'h0001 >= st_r.long_ms); // [RULE23]
      act_dir  = st_r.ctrl[`CTRL_TOGGLE] ? !st_r.dir
                 : st_r.ctrl[`CTRL_FIXDIR];                    // [RULE9] [RULE21]
      // Writes land in the access phase, reads are captured in setup
      apb_wr   = psel_in && penable_in && pwrite_in;
      apb_rd   = psel_in && !penable_in && !pwrite_in;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt          = st_r;
      st_nxt.move     = 1'b0;
      st_nxt.step     = 1'b0;
      st_nxt.stop     = 1'b0;
      st_nxt.resync   = 1'b0;
      st_nxt.prev_man = man_lvl;

      // ------------------------------------------------------------
      // Manual mode toggles on each debounced button press
      // ------------------------------------------------------------
      if (man_lvl && !st_r.prev_man) begin
         st_nxt.manual = !st_r.manual;                         // [RULE18] [RULE19]
         // Re-seed the edge detector so mode change makes no event
         st_nxt.resync = 1'b1;
         st_nxt.press  = blind_seq_pkg::PR_IDLE;
      end

      // ------------------------------------------------------------
      // Edge detector and millisecond tick
      // ------------------------------------------------------------
      // The detector follows whichever source is live; the resync
      // cycle only hides the step that a change of source makes.
      if (st_r.resync) begin
         st_nxt.prev_in = in_lvl;                              // [RULE20]
      end else begin
         st_nxt.prev_in = in_lvl;
      end

      // Free-running between presses; each press restarts it
      st_nxt.tick_cnt = ms_tick ? '0 : st_r.tick_cnt + `MS_CNT_W'(1);

      // ------------------------------------------------------------
      // Press tracking and command generation
      // ------------------------------------------------------------
      if (!(man_lvl && !st_r.prev_man)) begin
         case (st_r.press)
            blind_seq_pkg::PR_IDLE: begin
               if (rise) begin
                  st_nxt.press   = blind_seq_pkg::PR_SHORT;
                  st_nxt.held_ms = '0;
                  st_nxt.tick_cnt = '0;
                  // Shutter travelling: the press length decides later
                  if (!st_r.ctrl[`CTRL_BLINDS] && !st_r.moving) begin
                     st_nxt.dir    = act_dir;                  // [RULE8]
                     st_nxt.move   = 1'b1;                     // [RULE5]
                     st_nxt.moving = 1'b1;
                  end
               end
            end
            blind_seq_pkg::PR_SHORT: begin
               if (fall) begin
                  st_nxt.press = blind_seq_pkg::PR_IDLE;
                  if (st_r.ctrl[`CTRL_BLINDS]) begin
                     // Short press: step, or halt when travelling
                     if (!st_r.moving) begin
                        st_nxt.dir = act_dir;
                     end
                     st_nxt.step   = 1'b1;                     // [RULE12] [RULE14] [RULE22]
                     st_nxt.moving = 1'b0;
                  end
                  // Shutter quick release sends nothing [RULE10]
               end else if (ms_tick) begin
                  st_nxt.held_ms = st_r.held_ms + 16'h0001;
                  if (long_hit) begin
                     st_nxt.press = blind_seq_pkg::PR_LONG;
                     if (st_r.ctrl[`CTRL_BLINDS]) begin
                        st_nxt.dir    = act_dir;
                        st_nxt.move   = 1'b1;                  // [RULE13] [RULE6]
                        st_nxt.moving = 1'b1;
                     end else if (st_r.moving && !st_r.move) begin
                        st_nxt.moving = 1'b1;
                     end
                  end
               end
            end
            blind_seq_pkg::PR_LONG: begin
               if (fall) begin
                  st_nxt.press = blind_seq_pkg::PR_IDLE;
                  // Venetian release sends nothing: travel runs on
                  if (!st_r.ctrl[`CTRL_BLINDS]) begin
                     st_nxt.stop   = 1'b1;                     // [RULE11] [RULE10] [RULE22]
                     st_nxt.moving = 1'b0;
                  end
               end
            end
            default: begin
               st_nxt.press = blind_seq_pkg::PR_IDLE;
            end
         endcase
      end

      // A shutter already travelling gets no move from the next press;
      // if that press turns long, its release sends the stop.
      if (st_r.press == blind_seq_pkg::PR_IDLE && rise
          && !st_r.ctrl[`CTRL_BLINDS] && st_r.moving) begin
         st_nxt.moving = 1'b1;
      end

      if (st_nxt.move || st_nxt.step || st_nxt.stop) begin
         st_nxt.last_cmd = {st_nxt.dir, st_nxt.stop,
                            st_nxt.step, st_nxt.move};         // [RULE1]
      end

      // ------------------------------------------------------------
      // APB register writes
      // ------------------------------------------------------------
      if (apb_wr) begin
         if (is_addr(paddr_in, `ADDR_CTRL)) begin
            st_nxt.ctrl = pwdata_in[2:0];
         end else if (is_addr(paddr_in, `ADDR_LONG)) begin
            // Zero is stored as 1; either value makes a press long at the first ms tick
            st_nxt.long_ms = (pwdata_in[15:0] == 16'h0000)
                             ? 16'h0001 : pwdata_in[15:0];
         end
      end

      // ------------------------------------------------------------
      // Read data captured in the setup cycle, so that a status bit
      // cannot change under a running access
      // ------------------------------------------------------------
      if (apb_rd) begin
         st_nxt.rdata = 32'h0000_0000;
         if (is_addr(paddr_in, `ADDR_CTRL)) begin
            st_nxt.rdata[2:0] = st_r.ctrl;
         end else if (is_addr(paddr_in, `ADDR_LONG)) begin
            st_nxt.rdata[15:0] = st_r.long_ms;
         end else if (is_addr(paddr_in, `ADDR_STATUS)) begin
            st_nxt.rdata[`ST_MANUAL]  = st_r.manual;
            st_nxt.rdata[`ST_PRESSED] = st_r.prev_in;
            st_nxt.rdata[`ST_DIR]     = st_r.dir;
            st_nxt.rdata[`ST_MOVING]  = st_r.moving;
            st_nxt.rdata[`ST_LONG]    =
               (st_r.press == blind_seq_pkg::PR_LONG);
         end else if (is_addr(paddr_in, `ADDR_CMD)) begin
            st_nxt.rdata[3:0] = st_r.last_cmd;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Reset values come from the header; the first cycle is a resync
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r         <= '0;
         st_r.ctrl    <= `CTRL_RESET;
         st_r.long_ms <= `LONG_MS_DEFAULT;
         st_r.press   <= blind_seq_pkg::PR_IDLE;
         st_r.resync  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Zero wait states; unmapped addresses answer with an error
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !is_mapped(paddr_in);
   assign prdata_out  = st_r.rdata;

   // ---------------------------------------------------------------
   // Command objects and indicators
   // ---------------------------------------------------------------
   // Pulses last one cycle; the transceiver takes them with the
   // direction level, which holds until the next command.
   assign move_send_out  = st_r.move;                          // [RULE16]
   assign step_send_out  = st_r.step;
   assign stop_send_out  = st_r.stop;
   assign cmd_dir_out    = st_r.dir;
   assign manual_led_out = st_r.manual;                        // [RULE18]
   assign key_led_out    = st_r.manual && st_r.prev_in;        // [RULE17]

endmodule : blind_command_sequencer

//--- design/blind_seq_defs.svh
// Constants for the blind command sequencer: APB map, fields, timing.
// Assumes a 10 MHz clock; included by the package and both modules.
`ifndef BLIND_SEQ_DEFS_SVH
`define BLIND_SEQ_DEFS_SVH

`define CLK_HZ            10000000
// Debounce settle time in microseconds and derived cycle count;
// short settle suits clean contacts, raise it for bouncy ones
`define DEB_TIME_US       10
`define DEB_CYCLES        ((`CLK_HZ / 1000000) * `DEB_TIME_US)
`define DEB_CNT_W         17
// Long-press threshold default in milliseconds, counted in 1 ms ticks
`define LONG_MS_DEFAULT   16'h01F4
`define MS_CYCLES         ((`CLK_HZ / 1000) - 1)
`define MS_CNT_W          14

// Register byte addresses
`define ADDR_CTRL         12'h000
`define ADDR_LONG         12'h004
`define ADDR_STATUS       12'h008
`define ADDR_CMD          12'h00C

// CTRL fields
`define CTRL_BLINDS       0
`define CTRL_TOGGLE       1
`define CTRL_FIXDIR       2
`define CTRL_RESET        3'h0

// STATUS / CMD fields
`define ST_MANUAL         0
`define ST_PRESSED        1
`define ST_DIR            2
`define ST_MOVING         3
`define ST_LONG           4
`define CMD_MOVE          0
`define CMD_STEP          1
`define CMD_STOP          2
`define CMD_DIR           3

`endif

//--- design/blind_seq_pkg.sv
// Types shared by the blind command sequencer modules.
// Assumes the constants header is on the include path.
`include "blind_seq_defs.svh"

package blind_seq_pkg;

   // Press tracker, Gray coded along idle -> pressed -> long; long -> idle flips both bits
   typedef enum logic [1:0] {
      PR_IDLE  = 2'b00,
      PR_SHORT = 2'b01,
      PR_LONG  = 2'b11
   } press_state_t;

   typedef struct packed {
      logic                  out;
      logic [`DEB_CNT_W-1:0] cnt;
   } deb_state_t;

endpackage : blind_seq_pkg

//--- design/input_debounce.sv
// Debouncer for one contact: output follows input after it is stable.
// Assumes the input is synchronous to the clock.
`timescale 1ns/1ps
`include "blind_seq_defs.svh"

module input_debounce (
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   input  wire logic raw_in,
   input  wire logic force_in,
   input  wire logic force_val_in,
   output logic      level_out
);

   blind_seq_pkg::deb_state_t st_r;
   blind_seq_pkg::deb_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (force_in) begin
         // Force jumps straight to force_val_in and clears the settle count
         st_nxt.out = force_val_in;
         st_nxt.cnt = '0;
      end else if (raw_in == st_r.out) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt == `DEB_CNT_W'(`DEB_CYCLES - 1)) begin
         st_nxt.out = raw_in;                              // [RULE24]
         st_nxt.cnt = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + `DEB_CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_out = st_r.out;

endmodule : input_debounce

//--- test/blind_seq_monitor.sv
// Port checker for the blind command sequencer.
// Assumes it is bound to the sequencer top module.
`timescale 1ns/1ps
module blind_seq_monitor (
   input wire logic        ref_clk_in,
   input wire logic        resetn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        key_led_out,
   input wire logic        manual_led_out,
   input wire logic        move_send_out,
   input wire logic        step_send_out,
   input wire logic        stop_send_out,
   input wire logic        cmd_dir_out
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   wire logic any_cmd = move_send_out | step_send_out | stop_send_out;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   sequence s_acc;
      psel_in && penable_in;
   endsequence
   sequence s_cmd;
      any_cmd;
   endsequence
   a_ready_high: assert property (pready_out)
      else $error("pready low");
   a_err_access: assert property (pslverr_out |-> s_acc)
      else $error("slave error outside access phase");
   a_err_rdzero: assert property (pslverr_out && !pwrite_in |->
      prdata_out == 32'h0000_0000) else $error("unmapped read not zero");
   a_cmd_onehot: assert property ($onehot0({move_send_out,
      step_send_out, stop_send_out})) else $error("two commands at once");
   // Each command must be one pulse, never a burst
   a_cmd_pulse: assert property (s_cmd |=> (!any_cmd) [*8])
      else $error("command pulse repeated");
   a_dir_cause: assert property ($changed(cmd_dir_out) |-> s_cmd)
      else $error("direction moved without command");
   a_key_manual: assert property (key_led_out |-> manual_led_out)
      else $error("key led lit outside manual mode");
   a_mode_quiet: assert property ($changed(manual_led_out) |->
      !any_cmd) else $error("command on mode change");
endmodule : blind_seq_monitor

bind blind_command_sequencer blind_seq_monitor i_blind_seq_monitor (
   .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in),
   .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .key_led_out(key_led_out),
   .manual_led_out(manual_led_out), .move_send_out(move_send_out),
   .step_send_out(step_send_out), .stop_send_out(stop_send_out),
   .cmd_dir_out(cmd_dir_out));

//--- test/blind_actuator_model.sv
// Blind actuator model fed by the one-bit command pulses.
// Assumes one-cycle pulses qualified by the direction level.
`timescale 1ns/1ps
module blind_actuator_model (
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   input  wire logic move_in,
   input  wire logic step_in,
   input  wire logic stop_in,
   input  wire logic dir_in,
   output logic      moving_out,
   output int        pos_out
);
   // ------------------------------------------------------------
   // Travel has no end stop: only a command halts it
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         moving_out <= 1'b0;
         pos_out    <= 0;
      end else if (move_in) begin
         moving_out <= 1'b1;
      end else if (step_in) begin
         moving_out <= 1'b0;
         if (!moving_out)
            pos_out <= dir_in ? pos_out + 1 : pos_out - 1;
      end else if (stop_in) begin
         moving_out <= 1'b0;
      end
   end
endmodule : blind_actuator_model

//--- test/blind_command_sequencer_test.sv
// Self-checking bench: APB setup, bouncing presses, command queue.
// Assumes the defs header is on the include path; about 56k cycles.
`timescale 1ns/1ps
`include "blind_seq_defs.svh"
module blind_command_sequencer_test;
   localparam int DEB   = `DEB_CYCLES;
   // Long presses run past the 1 ms threshold that the bench programs
   localparam int LONG_HOLD = 12000;
   localparam int LIMIT = 3 * LONG_HOLD + 10 * (2 * DEB + 4000);
   localparam int MV = 4, ST = 8, SP = 16, DC = 2, OPP = 3;
   logic        ref_clk_in, resetn_in, psel, pen, pwr, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        phys, key, mkey, key_led, man_led, mv, st, sp, dir;
   logic        act_mv, err, in_man;
   int          failures, checked, last_dir, act_pos, p0;
   int          seed = 98174;
   int          exp_q[$];

   blind_command_sequencer i_blind_command_sequencer (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .phys_in(phys), .key_in(key),
      .manual_key_in(mkey), .key_led_out(key_led),
      .manual_led_out(man_led), .move_send_out(mv),
      .step_send_out(st), .stop_send_out(sp), .cmd_dir_out(dir));
   blind_actuator_model i_blind_actuator_model (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .move_in(mv),
      .step_in(st), .stop_in(sp), .dir_in(dir), .moving_out(act_mv),
      .pos_out(act_pos));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic int short_hold();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return 300 + (seed & 32'h7FFF_FFFF) % 3000;
   endfunction : short_hold

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge ref_clk_in);
      psel   <= 1'b1;
      pwr    <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      pen <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge ref_clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb

   task automatic rchk(string n, logic [11:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rchk

   task automatic drive(int which, logic v);
      case (which)
         0: phys <= v;
         1: key <= v;
         default: mkey <= v;
      endcase
   endtask : drive

   task automatic press(int which, int hold);
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk_in);
         drive(which, !i[0]);
      end
      repeat (DEB + hold) @(posedge ref_clk_in);
      chk("key led", 32'(which == 1 && in_man), 32'(key_led));
      drive(which, 1'b0);
      repeat (DEB + 500) @(posedge ref_clk_in);
   endtask : press

   task automatic finish_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // Each pulse is matched against the oldest expected command
   always @(posedge ref_clk_in) if ({mv, st, sp} !== 3'h0) begin
      int e;
      e = exp_q.size() > 0 ? exp_q.pop_front() : 0;
      chk("cmd kind", 32'(e / 4), {29'h0, sp, st, mv});
      if (e % 4 < 2)
         chk("cmd dir", 32'(e % 4), 32'(dir));
      if (e % 4 == OPP)
         chk("cmd dir", 32'(1 - last_dir), 32'(dir));
      last_dir = int'(dir);
   end

   // ------------------------------------------------------------
   // Clock, watchdog, sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   initial begin
      repeat (LIMIT) @(posedge ref_clk_in);
      failures++;
      finish_test();
   end

   initial begin
      {psel, pen, pwr, phys, key, mkey, in_man} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      resetn_in = 1'b0;
      repeat (16) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      rchk("ctrl", `ADDR_CTRL, 32'h0);
      rchk("long", `ADDR_LONG, 32'h1F4);
      apb(1'b1, `ADDR_LONG, 32'h0);
      rchk("long min", `ADDR_LONG, 32'h1);
      apb(1'b1, `ADDR_LONG, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, `ADDR_CTRL, 32'(short_hold() << 3) | 32'h4);
      rchk("ctrl fixed", `ADDR_CTRL, 32'h4);
      exp_q.push_back(MV + 1);
      exp_q.push_back(SP + DC);
      press(0, LONG_HOLD);
      chk("act still", 32'h0, 32'(act_mv));
      exp_q.push_back(MV + 1);
      press(0, short_hold());
      chk("act moving", 32'h1, 32'(act_mv));
      exp_q.push_back(SP + DC);
      press(0, LONG_HOLD);
      chk("act halted", 32'h0, 32'(act_mv));
      apb(1'b1, `ADDR_CTRL, 32'h1);
      exp_q.push_back(MV + 0);
      press(0, LONG_HOLD);
      exp_q.push_back(ST + 0);
      press(0, short_hold());
      chk("act slats", 32'h0, 32'(act_mv));
      apb(1'b1, `ADDR_CTRL, 32'h3);
      p0 = act_pos;
      exp_q.push_back(ST + DC);
      press(0, short_hold());
      exp_q.push_back(ST + OPP);
      press(0, short_hold());
      chk("act pos", 32'(p0), 32'(act_pos));
      apb(1'b1, `ADDR_CTRL, 32'h1);
      press(2, 200);
      in_man = 1'b1;
      chk("manual led", 32'h1, 32'(man_led));
      press(0, short_hold());
      exp_q.push_back(ST + 0);
      press(1, short_hold());
      phys <= 1'b1;
      press(2, 200);
      in_man = 1'b0;
      chk("manual off", 32'h0, 32'(man_led));
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk("status", 32'h2, rd & 32'h3);
      resetn_in <= 1'b0;
      phys <= 1'b0;
      repeat (16) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      rchk("ctrl again", `ADDR_CTRL, 32'h0);
      chk("queue left", 32'h0, 32'(exp_q.size()));
      finish_test();
   end
endmodule : blind_command_sequencer_test
